// ### hw/caf_pkg.sv
// package: register map, field layout and sizes of the acceptance filter
package caf_pkg;
	localparam int NUM_FILT    = 16;
	localparam int NUM_MASK    = 3;
	localparam int ADDR_W      = 7;
	localparam int DATA_W      = 16;
	localparam int SID_W       = 11;
	localparam int EID_W       = 18;
	localparam int BPTR_W      = 4;
	// register indices (word addresses)
	localparam logic [6:0] ADR_FSID_BASE = 7'h00; // 16 filter std words
	localparam logic [6:0] ADR_FEID_BASE = 7'h10; // 16 filter ext words
	localparam logic [6:0] ADR_MSID_BASE = 7'h20; // 3 mask std words
	localparam logic [6:0] ADR_MEID_BASE = 7'h24; // 3 mask ext words
	localparam logic [6:0] ADR_MSEL_LO   = 7'h28;
	localparam logic [6:0] ADR_MSEL_HI   = 7'h29;
	localparam logic [6:0] ADR_FEN       = 7'h2a;
	localparam logic [6:0] ADR_BPTR_BASE = 7'h2c; // 4 pointer words
	localparam logic [6:0] ADR_RESULT    = 7'h30;
	// std-identifier word layout
	localparam int SID_LSB   = 5;
	localparam int SID_MSB   = 15;
	localparam int XSEL_BIT  = 3;
	localparam int EIDH_MSB  = 1;
	localparam int EIDH_LSB  = 0;
	localparam logic [15:0] SIDW_IMPL = 16'hffeb; // bits 4 and 2 absent
	// reset values
	localparam logic [15:0] MSEL_RST  = 16'h0000;
	localparam logic [15:0] FEN_RST   = 16'hffff;
	localparam logic [15:0] BPTR_RST  = 16'h0000;
	localparam logic [1:0]  MSK_RSVD  = 2'h3;
	localparam logic [3:0]  BPTR_FIFO = 4'hf;
endpackage : caf_pkg

// ### hw/caf_match_cell.sv
// one filter compare: masked identifier and frame type check
`timescale 1ns/100ps
module caf_match_cell
	import caf_pkg::*;
(
	input  wire logic [15:0] f_sid_i,
	input  wire logic [15:0] f_eid_i,
	input  wire logic [15:0] m_sid_i,
	input  wire logic [15:0] m_eid_i,
	input  wire logic        enable_i,
	input  wire logic [10:0] rx_sid_i,
	input  wire logic [17:0] rx_eid_i,
	input  wire logic        rx_ext_i,
	output logic             hit_o
);
	logic [10:0] sid_diff;
	logic [17:0] eid_diff;
	logic        sid_ok;
	logic        eid_ok;
	logic        type_ok;

	// a set mask bit makes a compared bit; zero is don't-care
	assign sid_diff = (f_sid_i[SID_MSB:SID_LSB] ^ rx_sid_i)
		& m_sid_i[SID_MSB:SID_LSB];
	assign eid_diff = ({f_sid_i[EIDH_MSB:EIDH_LSB], f_eid_i} ^ rx_eid_i)
		& {m_sid_i[EIDH_MSB:EIDH_LSB], m_eid_i};
	assign sid_ok = ~|sid_diff;
	// extended bits only count for extended frames
	assign eid_ok = ~rx_ext_i | ~|eid_diff;
	// type select only counts when the mask asks for it
	assign type_ok = ~m_sid_i[XSEL_BIT]
		| (f_sid_i[XSEL_BIT] == rx_ext_i);
	assign hit_o = enable_i & sid_ok & eid_ok & type_ok;
endmodule : caf_match_cell

// ### hw/caf_filter_top.sv
// acceptance filter bank: registers, sixteen compares, winner select
//
// Contract
// - filter std bits give required identifier values
// - eighteen extended bits split across two registers
// - extended-only select counts only with type match
// - type-match bit forces frame type agreement
// - mask std bit one compares, zero ignores
// - mask bits 1-0 cover extended 17,16
// - mask source 00/01/10 picks mask, 11 reserved
// - two select registers, two bits per filter
// - sixteen filters each with two identifier registers
// - std words bits 4,2 read zero
// - identifiers undefined at reset, selects zero
// - disabled filter never matches
// - hit routes to filter's buffer pointer
`timescale 1ns/100ps
module caf_filter_top
	import caf_pkg::*;
#(
	parameter int NUM_FILTERS = 16
)
(
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	input  wire logic [caf_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [caf_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic [caf_pkg::DATA_W-1:0]     rdata_o,
	input  wire logic                      id_valid_i,
	input  wire logic [caf_pkg::SID_W-1:0] id_sid_i,
	input  wire logic [caf_pkg::EID_W-1:0] id_eid_i,
	input  wire logic                      id_ext_i,
	output logic                           acc_valid_o,
	output logic                           acc_miss_o,
	output logic [3:0]                     acc_filter_o,
	output logic [caf_pkg::BPTR_W-1:0]     acc_buf_o,
	output logic                           acc_fifo_o
);
	import caf_pkg::*;

	initial begin
		if (NUM_FILTERS != NUM_FILT)
			$error("caf_filter_top: only 16 filters supported");
	end

	// identifier storage has no reset; contents undefined at power-up
	logic [15:0] f_sid_q [NUM_FILT];
	logic [15:0] f_eid_q [NUM_FILT];
	logic [15:0] m_sid_q [NUM_MASK];
	logic [15:0] m_eid_q [NUM_MASK];
	logic [15:0] msel_lo_q;
	logic [15:0] msel_hi_q;
	logic [15:0] fen_q;
	logic [15:0] bptr_q [4];
	logic [15:0] rdata_q;
	logic        acc_valid_q;
	logic        acc_miss_q;
	logic [3:0]  acc_filter_q;
	logic [3:0]  acc_buf_q;
	logic        acc_fifo_q;
	logic [15:0] result_q;

	// address decode
	wire         in_fsid  = addr_i[6:4] == ADR_FSID_BASE[6:4];
	wire         in_feid  = addr_i[6:4] == ADR_FEID_BASE[6:4];
	wire         in_msid  = (addr_i[6:2] == ADR_MSID_BASE[6:2])
		&& (addr_i[1:0] != 2'h3);
	wire         in_meid  = (addr_i[6:2] == ADR_MEID_BASE[6:2])
		&& (addr_i[1:0] != 2'h3);
	wire         in_bptr  = addr_i[6:2] == ADR_BPTR_BASE[6:2];
	wire [3:0]   idx4     = addr_i[3:0];
	wire [1:0]   idx2     = addr_i[1:0];
	wire [15:0]  sid_wr   = wdata_i & SIDW_IMPL;

	// filter identifier words, one pair per filter
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && in_fsid)
			f_sid_q[idx4] <= sid_wr;
		if (wr_i && in_feid)
			f_eid_q[idx4] <= wdata_i;
	end

	// mask words, three masks
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && in_msid)
			m_sid_q[idx2] <= sid_wr;
		if (wr_i && in_meid)
			m_eid_q[idx2] <= wdata_i;
	end

	// control words with defined reset
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			msel_lo_q <= MSEL_RST;
			msel_hi_q <= MSEL_RST;
			fen_q     <= FEN_RST;
			for (int i = 0; i < 4; i++)
				bptr_q[i] <= BPTR_RST;
		end else if (wr_i) begin
			if (addr_i == ADR_MSEL_LO)
				msel_lo_q <= wdata_i;
			if (addr_i == ADR_MSEL_HI)
				msel_hi_q <= wdata_i;
			if (addr_i == ADR_FEN)
				fen_q <= wdata_i;
			if (in_bptr)
				bptr_q[idx2] <= wdata_i;
		end
	end

	// read mux; unmapped addresses read zero
	logic [15:0] rd_mux;
	always_comb begin
		rd_mux = 16'h0000;
		if (in_fsid)
			rd_mux = f_sid_q[idx4] & SIDW_IMPL;
		else if (in_feid)
			rd_mux = f_eid_q[idx4];
		else if (in_msid)
			rd_mux = m_sid_q[idx2] & SIDW_IMPL;
		else if (in_meid)
			rd_mux = m_eid_q[idx2];
		else if (in_bptr)
			rd_mux = bptr_q[idx2];
		else if (addr_i == ADR_MSEL_LO)
			rd_mux = msel_lo_q;
		else if (addr_i == ADR_MSEL_HI)
			rd_mux = msel_hi_q;
		else if (addr_i == ADR_FEN)
			rd_mux = fen_q;
		else if (addr_i == ADR_RESULT)
			rd_mux = result_q;
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			rdata_q <= 16'h0000;
		else
			rdata_q <= rd_i ? rd_mux : 16'h0000;
	end

	// per-filter compare against its selected mask
	wire [31:0] msel_all = {msel_hi_q, msel_lo_q};
	logic [NUM_FILT-1:0] hit;
	logic [1:0]          msrc [NUM_FILT];
	for (genvar g = 0; g < NUM_FILT; g++) begin : g_filt
		assign msrc[g] = msel_all[2*g+1:2*g];
		// reserved source feeds mask 0 but clears the enable, so the filter cannot hit
		wire rsvd = msrc[g] == MSK_RSVD;
		wire [1:0] mi = rsvd ? 2'h0 : msrc[g];
		caf_match_cell u_cell (
			.f_sid_i  (f_sid_q[g]),
			.f_eid_i  (f_eid_q[g]),
			.m_sid_i  (m_sid_q[mi]),
			.m_eid_i  (m_eid_q[mi]),
			.enable_i (fen_q[g] & ~rsvd),
			.rx_sid_i (id_sid_i),
			.rx_eid_i (id_eid_i),
			.rx_ext_i (id_ext_i),
			.hit_o    (hit[g])
		);
	end

	// priority pick: lowest index wins
	logic [3:0] win;
	always_comb begin
		win = 4'h0;
		for (int i = NUM_FILT - 1; i >= 0; i--)
			if (hit[i])
				win = 4'(i);
	end
	wire [15:0] win_word = bptr_q[win[3:2]];
	wire [3:0]  win_ptr  = win_word[4*win[1:0] +: 4];
	wire        any_hit  = |hit;

	// result registered one cycle after the identifier strobe
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			acc_valid_q  <= 1'b0;
			acc_miss_q   <= 1'b0;
			acc_filter_q <= 4'h0;
			acc_buf_q    <= 4'h0;
			acc_fifo_q   <= 1'b0;
			result_q     <= 16'h0000;
		end else begin
			acc_valid_q <= id_valid_i & any_hit;
			acc_miss_q  <= id_valid_i & ~any_hit;
			if (id_valid_i && any_hit) begin
				acc_filter_q <= win;
				acc_buf_q    <= win_ptr;
				acc_fifo_q   <= win_ptr == BPTR_FIFO;
			end
			// status: bit 15 hit, 14 fifo, 7:4 buffer, 3:0 filter
			if (id_valid_i)
				result_q <= {any_hit, any_hit && win_ptr == BPTR_FIFO,
					6'h00, win_ptr, win};
		end
	end

	assign rdata_o      = rdata_q;
	assign acc_valid_o  = acc_valid_q;
	assign acc_miss_o   = acc_miss_q;
	assign acc_filter_o = acc_filter_q;
	assign acc_buf_o    = acc_buf_q;
	assign acc_fifo_o   = acc_fifo_q;

	// checks
	sid_zero_bits_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		rd_i && (in_fsid || in_msid) |=> rdata_o[4] == 1'b0
		&& rdata_o[2] == 1'b0) else $error("unimplemented bit read one");
	msel_reset_a: assert property (@(posedge sys_clk_i)
		rst_i |=> msel_lo_q == 16'h0000 && msel_hi_q == 16'h0000)
		else $error("mask select not cleared");
	fen_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		id_valid_i && fen_q == 16'h0000 |=> !acc_valid_o)
		else $error("hit with all filters off");
	buf_route_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		id_valid_i && any_hit |=> acc_buf_o == $past(win_ptr)
		&& acc_filter_o == $past(win)) else $error("bad buffer route");
	lowest_win_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		id_valid_i && hit[0] |=> acc_valid_o && acc_filter_o == 4'h0)
		else $error("filter 0 not chosen");
	fifo_flag_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		acc_valid_o |-> acc_fifo_o == (acc_buf_o == 4'hf))
		else $error("fifo flag wrong");
	rsvd_src_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		msel_lo_q[1:0] == 2'h3 |-> !hit[0])
		else $error("reserved source hit");
	one_result_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		id_valid_i |=> acc_valid_o ^ acc_miss_o)
		else $error("result not unique");
	std_type_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		m_sid_q[0][3] && f_sid_q[0][3] && !id_ext_i
		&& msel_lo_q[1:0] == 2'h0 |-> !hit[0])
		else $error("type select ignored");
	read_once_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!rd_i |=> rdata_o == 16'h0000) else $error("stale read data");

	hit_cov_c:  cover property (@(posedge sys_clk_i) acc_valid_o);
	miss_cov_c: cover property (@(posedge sys_clk_i) acc_miss_o);
	fifo_cov_c: cover property (@(posedge sys_clk_i) acc_fifo_o && acc_valid_o);
	multi_cov_c: cover property (@(posedge sys_clk_i)
		id_valid_i && hit[1] && hit[5]);
endmodule : caf_filter_top

// ### tb/caf_rx_model.sv
// behavioural receive engine that hands identifiers to the filter bank
`timescale 1ns/100ps
module caf_rx_model
	import caf_pkg::*;
(
	input  wire logic                  sys_clk_i,
	output logic                       id_valid_o,
	output logic [caf_pkg::SID_W-1:0]  id_sid_o,
	output logic [caf_pkg::EID_W-1:0]  id_eid_o,
	output logic                       id_ext_o
);
	initial begin
		id_valid_o = 1'b0;
		id_sid_o   = '0;
		id_eid_o   = '0;
		id_ext_o   = 1'b0;
	end

	// one-cycle strobe with the identifier beside it
	task automatic send(input logic [10:0] s, input logic [17:0] e,
		input logic x);
		@(posedge sys_clk_i);
		id_valid_o <= 1'b1;
		id_sid_o   <= s;
		id_eid_o   <= e;
		id_ext_o   <= x;
		@(posedge sys_clk_i);
		// stale ids flip so nothing can lean on a held value
		id_valid_o <= 1'b0;
		id_sid_o   <= ~s;
		id_eid_o   <= ~e;
		id_ext_o   <= ~x;
	endtask : send
endmodule : caf_rx_model

// ### tb/tb_top.sv
// self-checking bench for the acceptance filter bank
`timescale 1ns/100ps
module tb_top;
	import caf_pkg::*;
	logic        sys_clk_i, rst_i, wr_i, rd_i, id_valid_i, id_ext_i;
	logic        acc_valid_o, acc_miss_o, acc_fifo_o;
	logic [6:0]  addr_i;
	logic [15:0] wdata_i, rdata_o;
	logic [15:0] sh [0:127];
	logic [10:0] id_sid_i;
	logic [17:0] id_eid_i;
	logic [3:0]  acc_filter_o, acc_buf_o;
	int          failures = 0;
	int          n_checks = 0;

	caf_filter_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .id_valid_i(id_valid_i), .id_sid_i(id_sid_i),
		.id_eid_i(id_eid_i), .id_ext_i(id_ext_i),
		.acc_valid_o(acc_valid_o), .acc_miss_o(acc_miss_o),
		.acc_filter_o(acc_filter_o), .acc_buf_o(acc_buf_o),
		.acc_fifo_o(acc_fifo_o));
	caf_rx_model eng (.sys_clk_i(sys_clk_i), .id_valid_o(id_valid_i),
		.id_sid_o(id_sid_i), .id_eid_o(id_eid_i), .id_ext_o(id_ext_i));

	function automatic logic mapped(input logic [6:0] a);
		return a < 7'h23 || (a > 7'h23 && a < 7'h27) ||
			(a > 7'h27 && a < 7'h2b) || (a > 7'h2b && a < 7'h30);
	endfunction : mapped

	// lowest enabled filter whose masked compare passes, else -1
	function automatic int winner(input logic [10:0] s,
		input logic [17:0] e, input logic x);
		logic [15:0] fs, ms;
		logic [1:0]  sel;
		for (int f = 0; f < NUM_FILT; f++) begin
			fs  = sh[f];
			sel = 2'(sh[ADR_MSEL_LO + f / 8] >> (2 * (f % 8)));
			ms  = sh[ADR_MSID_BASE + sel];
			if (sh[ADR_FEN][f] && sel != MSK_RSVD &&
				((fs[15:5] ^ s) & ms[15:5]) == 11'h0 &&
				(!x || (({fs[1:0], sh[16 + f]} ^ e) &
				{ms[1:0], sh[ADR_MEID_BASE + sel]}) == 18'h0) &&
				(!ms[3] || fs[3] == x))
				return f;
		end
		return -1;
	endfunction : winner

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic [6:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		// unimplemented std-word bits never store
		if (mapped(a))
			sh[a] = d & ((a < 7'h10 || (a > 7'h1f && a < 7'h23)) ?
				SIDW_IMPL : 16'hffff);
	endtask : wreg

	task automatic rreg(input logic [6:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask : rreg

	task automatic send_chk(input logic [10:0] s, input logic [17:0] e,
		input logic x);
		int          w;
		logic [3:0]  bp;
		logic [15:0] st;
		w = winner(s, e, x);
		eng.send(s, e, x);
		#1;
		chk({15'h0, acc_valid_o}, {15'h0, w >= 0});
		chk({15'h0, acc_miss_o}, {15'h0, w < 0});
		if (w >= 0) begin
			bp = 4'(sh[ADR_BPTR_BASE + w / 4] >> (4 * (w % 4)));
			chk({12'h0, acc_filter_o}, 16'(w));
			chk({acc_fifo_o, 11'h0, acc_buf_o},
				{bp == BPTR_FIFO, 11'h0, bp});
			// status word latched at the strobe must agree too
			rreg(ADR_RESULT, st);
			chk(st, {1'b1, bp == BPTR_FIFO, 6'h00, bp, 4'(w)});
		end
	endtask : send_chk

	task automatic test_done();
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// about eight times the expected run
	initial begin
		#200000;
		failures++;
		test_done();
	end

	initial begin
		logic [15:0] d;
		logic [10:0] standard_identifier_bits;
		logic [17:0] extended_identifier_bits;
		logic        x;
		int          f;
		rst_i   = 1'b1;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		addr_i  = 7'h0;
		wdata_i = 16'h0;
		foreach (sh[i]) sh[i] = 16'h0;
		sh[ADR_FEN] = FEN_RST;
		void'($urandom(32'h6de6));
		repeat (20) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int a = 'h28; a < 'h30; a++) begin
			rreg(7'(a), d);
			chk(d, sh[a]);
		end
		$display("test reset values done");
		// round 0 all reserved selects, round 1 mask 0 open to all
		for (int r = 0; r < 6; r++) begin
			for (int a = 0; a < 'h31; a++) begin
				d = 16'($urandom);
				if (a == 'h2a) d = d | 16'($urandom);
				if (a > 'h1f && a < 'h27) d = d & 16'($urandom);
				if (r == 0) d = 16'hffff;
				if (r == 1) d = (a == 'h2a) ? 16'hffff : 16'h0;
				wreg(7'(a), d);
			end
			for (int a = 0; a < 'h30; a++) begin
				rreg(7'(a), d);
				chk(d, sh[a]);
			end
			for (int k = 0; k < 60; k++) begin
				f   = $urandom % 16;
				standard_identifier_bits = sh[f][15:5] ^ (($urandom % 3 == 0) ?
					11'h1 << ($urandom % 11) : 11'h0);
				extended_identifier_bits = {sh[f][1:0], sh[16 + f]} ^ (($urandom % 3 == 0) ?
					18'h1 << ($urandom % 18) : 18'h0);
				x   = ($urandom % 4 == 0) ? ~sh[f][3] : sh[f][3];
				send_chk(standard_identifier_bits, extended_identifier_bits, x);
			end
			$display("test round %0d done", r);
		end
		test_done();
	end
endmodule : tb_top
